// >>> design/tgc_count8.sv
// Purpose: Eight-bit up counter with period match and wrap pulse.
// Assumes: tick is a one-cycle enable from a divider.
// Notes:   A write wins over an increment in the same cycle.
`timescale 1ns/1ps
module tgc_count8 (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       tick,
  input  wire logic [7:0] limit,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] count,
  output logic            wrap
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 8'h00;
      wrap  <= 1'b0;
    end else begin
      wrap <= 1'b0;
      if (wr_en) begin
        count <= wr_data;
      end else if (tick) begin
        if (count == limit) begin
          count <= 8'h00; // [R3] [R4]
          wrap  <= 1'b1;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end
endmodule

// >>> design/tgc_pkg.sv
// Purpose: Constants and types shared by the timer gate and event block.
// Assumes: AHB-Lite word registers, one 50 MHz clock.
// Notes:   Offsets are byte addresses on the low eight address bits.
//
// How it works
// [R1] Two-bit select picks pin, overflow or match
// [R2] Polarity bit applies to every gate source
// [R3] Companion timer wrap FFh to 00h pulses gate
// [R4] Period timer clears after match, pulses gate
// [R5] Toggle mode flips gate on each rising edge
// [R6] Toggle disabled holds the flip-flop cleared
// [R7] Gate status always shows present gate level
// [R8] Software enables single pulse, then arms it
// [R9] Armed flag opens counting at next edge
// [R10] Armed flag self-clears at trailing gate edge
// [R11] After disarm, gate events never count again
// [R12] Clearing single pulse enable clears armed flag
// [R13] Toggle plus single pulse counts one cycle
// [R14] Falling gate status sets event flag, request
// [R15] Event flag works without gate count enable
// [R16] Count wraps FFFFh to 0000h, sets overflow flag
// [R17] Overflow request only while its enable set
// [R18] Compare trigger in mode 1011 clears count
// [R19] Trigger reset needs timer or synchronous mode
// [R20] Count write beats a same-cycle trigger reset
// [R21] Trigger reset never sets the overflow flag
// [R22] Gate enable off counts whenever run is set
// [R23] Gate enable on counts only at active level
// [R24] Assignment field routes compare units here
// [R25] Selected gate source synchronised before use
package tgc_pkg;

  localparam logic [7:0] TGC_OFF_CNT_LO   = 8'h00;
  localparam logic [7:0] TGC_OFF_CNT_HI   = 8'h04;
  localparam logic [7:0] TGC_OFF_CTRL     = 8'h08;
  localparam logic [7:0] TGC_OFF_GATE     = 8'h0C;
  localparam logic [7:0] TGC_OFF_ASSIGN   = 8'h10;
  localparam logic [7:0] TGC_OFF_IRQ      = 8'h14;
  localparam logic [7:0] TGC_OFF_AUX      = 8'h18;
  localparam logic [7:0] TGC_OFF_PER_LIM  = 8'h1C;
  localparam logic [7:0] TGC_OFF_C8_CNT   = 8'h20;
  localparam logic [7:0] TGC_OFF_PER_CNT  = 8'h24;

  localparam int TGC_CTRL_RUN   = 0;
  localparam int TGC_GATE_GCE   = 7;
  localparam int TGC_GATE_POL   = 6;
  localparam int TGC_GATE_TM    = 5;
  localparam int TGC_GATE_SPM   = 4;
  localparam int TGC_GATE_ARM   = 3;
  localparam int TGC_GATE_VAL   = 2;
  localparam int TGC_GATE_GSS   = 0;
  localparam int TGC_IRQ_OVF_F  = 0;
  localparam int TGC_IRQ_GEV_F  = 1;
  localparam int TGC_IRQ_OVF_E  = 4;
  localparam int TGC_IRQ_GEV_E  = 5;
  localparam int TGC_AUX_C8_RUN = 0;
  localparam int TGC_AUX_PR_RUN = 1;

  localparam logic [15:0] TGC_CNT_RST     = 16'h0000;
  localparam logic [15:0] TGC_CNT_MAX     = 16'hFFFF;
  localparam logic [7:0]  TGC_BYTE_RST    = 8'h00;
  localparam logic [7:0]  TGC_PER_LIM_RST = 8'hFF;
  localparam logic [7:0]  TGC_C8_LIMIT    = 8'hFF;

  localparam logic [1:0] TGC_GSS_PIN = 2'b00;
  localparam logic [1:0] TGC_GSS_OVF = 2'b01;
  localparam logic [1:0] TGC_GSS_PER = 2'b10;
  localparam logic [1:0] TGC_ASG_BOTH   = 2'b10;
  localparam logic [1:0] TGC_ASG_SECOND = 2'b01;
  localparam logic [3:0] TGC_CMP_SEVT   = 4'hB;

  localparam int TGC_CLK_HZ   = 50000000;
  localparam int TGC_TICK_HZ  = 12500000;
  localparam int TGC_TICK_DIV = TGC_CLK_HZ / TGC_TICK_HZ;

  typedef enum logic [1:0] {
    TGC_SP_IDLE,
    TGC_SP_ARMED,
    TGC_SP_OPEN
  } tgc_sp_t;

endpackage

// >>> design/tgc_sync2.sv
// Purpose: Two-flop synchroniser for one level.
// Assumes: Single clock domain on the output side.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module tgc_sync2 (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// >>> design/tgc_timer3_gate.sv
// Purpose: Sixteen-bit timer with gate control, single pulse capture,
//          gate event and overflow flags, and compare trigger reset.
// Assumes: AHB-Lite slave with word accesses; gate pin already
//          synchronous, but the selected source is still resynchronised.
// Notes:   Writes take no wait state; reads take one.
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module tgc_timer3_gate
  import tgc_pkg::*;
#(
  parameter int TICK_DIV = TGC_TICK_DIV
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic        gate_input_pin,
  input  wire logic [3:0]  cmp1_mode_field,
  input  wire logic [3:0]  cmp2_mode_field,
  input  wire logic        cmp1_trigger,
  input  wire logic        cmp2_trigger,
  output logic             gate_event_irq,
  output logic             overflow_irq
);

  logic        wr_q;
  logic        rd_q;
  logic [7:0]  waddr_q;
  logic [7:0]  raddr_q;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_ctrl;
  logic        wr_gate;
  logic        wr_asg;
  logic        wr_irq;
  logic        wr_aux;
  logic        wr_plim;
  logic        wr_c8;
  logic        wr_pcnt;
  logic [31:0] rdata_d;

  logic [15:0] cnt_q;
  logic        run_q;
  logic        gce_q;
  logic        pol_q;
  logic        tm_q;
  logic        spm_q;
  logic [1:0]  gss_q;
  logic [1:0]  asg_q;
  logic        ovf_flag_q;
  logic        gev_flag_q;
  logic        ovf_ie_q;
  logic        gev_ie_q;
  logic        c8_run_q;
  logic        per_run_q;
  logic [7:0]  plim_q;

  logic [7:0]  div_q;
  logic        tick_q;
  logic [7:0]  c8_cnt;
  logic [7:0]  per_cnt;
  logic        c8_wrap;
  logic        per_wrap;

  logic        src_raw;
  logic        src_s;
  logic        g_act;
  logic        g_act_q;
  logic        tff_q;
  logic        tg;
  logic        tg_q;
  logic        gval_d;
  logic        gval_q;
  tgc_sp_t     sp_q;

  logic        cnt_inc;
  logic        sevt_hit;
  logic        ovf_set;
  logic        gev_set;

  // Bus front end. A read waits one cycle so that hrdata is registered
  // and sees any write accepted just before it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      waddr_q   <= 8'h00;
      raddr_q   <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (rd_q) begin
        rd_q      <= 1'b0;
        hrdata    <= rdata_d;
        hreadyout <= 1'b1;
      end else if (hsel && htrans[1] && hready) begin
        if (hwrite) begin
          wr_q    <= 1'b1;
          waddr_q <= haddr[7:0];
        end else begin
          rd_q      <= 1'b1;
          raddr_q   <= haddr[7:0];
          hreadyout <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    wr_lo   = 1'b0;
    wr_hi   = 1'b0;
    wr_ctrl = 1'b0;
    wr_gate = 1'b0;
    wr_asg  = 1'b0;
    wr_irq  = 1'b0;
    wr_aux  = 1'b0;
    wr_plim = 1'b0;
    wr_c8   = 1'b0;
    wr_pcnt = 1'b0;
    if (wr_q) begin
      if (waddr_q == TGC_OFF_CNT_LO) begin
        wr_lo = 1'b1;
      end else if (waddr_q == TGC_OFF_CNT_HI) begin
        wr_hi = 1'b1;
      end else if (waddr_q == TGC_OFF_CTRL) begin
        wr_ctrl = 1'b1;
      end else if (waddr_q == TGC_OFF_GATE) begin
        wr_gate = 1'b1;
      end else if (waddr_q == TGC_OFF_ASSIGN) begin
        wr_asg = 1'b1;
      end else if (waddr_q == TGC_OFF_IRQ) begin
        wr_irq = 1'b1;
      end else if (waddr_q == TGC_OFF_AUX) begin
        wr_aux = 1'b1;
      end else if (waddr_q == TGC_OFF_PER_LIM) begin
        wr_plim = 1'b1;
      end else if (waddr_q == TGC_OFF_C8_CNT) begin
        wr_c8 = 1'b1;
      end else if (waddr_q == TGC_OFF_PER_CNT) begin
        wr_pcnt = 1'b1;
      end
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (raddr_q == TGC_OFF_CNT_LO) begin
      rdata_d[7:0] = cnt_q[7:0];
    end else if (raddr_q == TGC_OFF_CNT_HI) begin
      rdata_d[7:0] = cnt_q[15:8];
    end else if (raddr_q == TGC_OFF_CTRL) begin
      rdata_d[TGC_CTRL_RUN] = run_q;
    end else if (raddr_q == TGC_OFF_GATE) begin
      rdata_d[TGC_GATE_GCE]         = gce_q;
      rdata_d[TGC_GATE_POL]         = pol_q;
      rdata_d[TGC_GATE_TM]          = tm_q;
      rdata_d[TGC_GATE_SPM]         = spm_q;
      rdata_d[TGC_GATE_ARM]         = (sp_q != TGC_SP_IDLE);
      rdata_d[TGC_GATE_VAL]         = gval_q; // [R7]
      rdata_d[TGC_GATE_GSS+:2]      = gss_q;
    end else if (raddr_q == TGC_OFF_ASSIGN) begin
      rdata_d[1:0] = asg_q;
    end else if (raddr_q == TGC_OFF_IRQ) begin
      rdata_d[TGC_IRQ_OVF_F] = ovf_flag_q;
      rdata_d[TGC_IRQ_GEV_F] = gev_flag_q;
      rdata_d[TGC_IRQ_OVF_E] = ovf_ie_q;
      rdata_d[TGC_IRQ_GEV_E] = gev_ie_q;
    end else if (raddr_q == TGC_OFF_AUX) begin
      rdata_d[TGC_AUX_C8_RUN] = c8_run_q;
      rdata_d[TGC_AUX_PR_RUN] = per_run_q;
    end else if (raddr_q == TGC_OFF_PER_LIM) begin
      rdata_d[7:0] = plim_q;
    end else if (raddr_q == TGC_OFF_C8_CNT) begin
      rdata_d[7:0] = c8_cnt;
    end else if (raddr_q == TGC_OFF_PER_CNT) begin
      rdata_d[7:0] = per_cnt;
    end
  end

  // Control registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q     <= 1'b0;
      gce_q     <= 1'b0;
      pol_q     <= 1'b0;
      tm_q      <= 1'b0;
      spm_q     <= 1'b0;
      gss_q     <= TGC_GSS_PIN;
      asg_q     <= 2'b00;
      ovf_ie_q  <= 1'b0;
      gev_ie_q  <= 1'b0;
      c8_run_q  <= 1'b0;
      per_run_q <= 1'b0;
      plim_q    <= TGC_PER_LIM_RST;
    end else begin
      if (wr_ctrl) begin
        run_q <= hwdata[TGC_CTRL_RUN];
      end
      if (wr_gate) begin
        gce_q <= hwdata[TGC_GATE_GCE];
        pol_q <= hwdata[TGC_GATE_POL];
        tm_q  <= hwdata[TGC_GATE_TM];
        spm_q <= hwdata[TGC_GATE_SPM];
        gss_q <= hwdata[TGC_GATE_GSS+:2];
      end
      if (wr_asg) begin
        asg_q <= hwdata[1:0];
      end
      if (wr_irq) begin
        ovf_ie_q <= hwdata[TGC_IRQ_OVF_E];
        gev_ie_q <= hwdata[TGC_IRQ_GEV_E];
      end
      if (wr_aux) begin
        c8_run_q  <= hwdata[TGC_AUX_C8_RUN];
        per_run_q <= hwdata[TGC_AUX_PR_RUN];
      end
      if (wr_plim) begin
        plim_q <= hwdata[7:0];
      end
    end
  end

  // Timer tick divider: every count runs at the instruction rate.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q  <= 8'h00;
      tick_q <= 1'b0;
    end else if (div_q == 8'(TICK_DIV - 1)) begin
      div_q  <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  tgc_count8 u_companion (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick_q && c8_run_q),
    .limit   (TGC_C8_LIMIT),
    .wr_en   (wr_c8),
    .wr_data (hwdata[7:0]),
    .count   (c8_cnt),
    .wrap    (c8_wrap)
  );

  tgc_count8 u_period (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick_q && per_run_q),
    .limit   (plim_q),
    .wr_en   (wr_pcnt),
    .wr_data (hwdata[7:0]),
    .count   (per_cnt),
    .wrap    (per_wrap)
  );

  // Gate path: select, resynchronise, polarity, toggle, single pulse.
  always_comb begin
    case (gss_q)
      TGC_GSS_PIN: src_raw = gate_input_pin; // [R1]
      TGC_GSS_OVF: src_raw = c8_wrap;        // [R1] [R3]
      TGC_GSS_PER: src_raw = per_wrap;       // [R1] [R4]
      default:     src_raw = 1'b0;
    endcase
  end

  tgc_sync2 u_gate_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (src_raw),
    .q       (src_s)
  ); // [R25]

  assign g_act = pol_q ? src_s : ~src_s; // [R2] [R23]
  assign tg    = tm_q ? tff_q : g_act;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      g_act_q <= 1'b0;
      tff_q   <= 1'b0;
      tg_q    <= 1'b0;
    end else begin
      g_act_q <= g_act;
      tg_q    <= tg;
      if (!tm_q) begin
        tff_q <= 1'b0; // [R6]
      end else if (g_act && !g_act_q) begin
        tff_q <= ~tff_q; // [R5]
      end
    end
  end

  // Software writes take priority over the hardware clear; an arm
  // request is honoured only with single pulse enabled.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_q <= TGC_SP_IDLE;
    end else if (wr_gate && !hwdata[TGC_GATE_SPM]) begin
      sp_q <= TGC_SP_IDLE; // [R12]
    end else if (wr_gate && !hwdata[TGC_GATE_ARM]) begin
      sp_q <= TGC_SP_IDLE;
    end else if (wr_gate && sp_q == TGC_SP_IDLE) begin
      sp_q <= TGC_SP_ARMED; // [R8]
    end else begin
      case (sp_q)
        TGC_SP_ARMED: begin
          if (tg && !tg_q) begin
            sp_q <= TGC_SP_OPEN; // [R9]
          end
        end
        TGC_SP_OPEN: begin
          if (!tg && tg_q) begin
            sp_q <= TGC_SP_IDLE; // [R10]
          end
        end
        default: sp_q <= TGC_SP_IDLE;
      endcase
    end
  end

  // With toggle on, tg spans a whole source period, so the open
  // window covers exactly one cycle of the source.
  assign gval_d = spm_q ? (tg && sp_q == TGC_SP_OPEN) : tg; // [R11] [R13]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gval_q <= 1'b0;
    end else begin
      gval_q <= gval_d; // [R7]
    end
  end

  // Counter.
  assign cnt_inc  = run_q && tick_q && (!gce_q || gval_q); // [R22] [R23]
  assign sevt_hit = (asg_q == TGC_ASG_BOTH && cmp1_trigger
                     && cmp1_mode_field == TGC_CMP_SEVT)
                 || ((asg_q == TGC_ASG_BOTH || asg_q == TGC_ASG_SECOND)
                     && cmp2_trigger
                     && cmp2_mode_field == TGC_CMP_SEVT); // [R18] [R24]
  assign ovf_set  = cnt_inc && cnt_q == TGC_CNT_MAX && !wr_lo && !wr_hi
                 && !sevt_hit; // [R16] [R21]
  assign gev_set  = gval_q && !gval_d; // [R14] [R15]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= TGC_CNT_RST;
    end else if (wr_lo) begin
      cnt_q[7:0] <= hwdata[7:0]; // [R20]
    end else if (wr_hi) begin
      cnt_q[15:8] <= hwdata[7:0]; // [R20]
    end else if (sevt_hit) begin
      cnt_q <= TGC_CNT_RST; // [R18] [R19]
    end else if (cnt_inc) begin
      cnt_q <= cnt_q + 16'h0001; // [R16]
    end
  end

  // Flags clear by writing one; a set in the same cycle wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_flag_q <= 1'b0;
      gev_flag_q <= 1'b0;
    end else begin
      if (ovf_set) begin
        ovf_flag_q <= 1'b1; // [R16]
      end else if (wr_irq && hwdata[TGC_IRQ_OVF_F]) begin
        ovf_flag_q <= 1'b0;
      end
      if (gev_set) begin
        gev_flag_q <= 1'b1; // [R14]
      end else if (wr_irq && hwdata[TGC_IRQ_GEV_F]) begin
        gev_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_irq   <= 1'b0;
      gate_event_irq <= 1'b0;
    end else begin
      overflow_irq   <= ovf_flag_q && ovf_ie_q; // [R17]
      gate_event_irq <= gev_flag_q && gev_ie_q; // [R14]
    end
  end

endmodule

// >>> sim/testbench.sv
// Purpose: Self-checking bench for the timer gate and event block.
// Assumes: tgc_far stands for the gate pin and the compare units.
// Notes:   A tick divider of two keeps the counting scenarios short.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin check_count++; if ((got) !== (exp)) begin failures++; \
  $display("mismatch at %0t got %0h exp %0h", $time, got, exp); end end

module testbench
  import tgc_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic        gate_input_pin;
  logic [3:0]  cmp1_mode_field;
  logic [3:0]  cmp2_mode_field;
  logic        cmp1_trigger;
  logic        cmp2_trigger;
  logic        gate_event_irq;
  logic        overflow_irq;
  logic [7:0]  rv;
  int          failures;
  int          check_count;

  tgc_timer3_gate #(.TICK_DIV(2)) u_tgc_timer3_gate (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .gate_input_pin(gate_input_pin), .cmp1_mode_field(cmp1_mode_field),
    .cmp2_mode_field(cmp2_mode_field), .cmp1_trigger(cmp1_trigger),
    .cmp2_trigger(cmp2_trigger), .gate_event_irq(gate_event_irq),
    .overflow_irq(overflow_irq)
  );
  tgc_far u_tgc_far (
    .hclk(hclk), .gate_input_pin(gate_input_pin),
    .cmp1_mode_field(cmp1_mode_field), .cmp2_mode_field(cmp2_mode_field),
    .cmp1_trigger(cmp1_trigger), .cmp2_trigger(cmp2_trigger)
  );

  always #10 hclk = ~hclk;

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    hsel   <= 1'b1;
    hsize  <= 3'h2;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    haddr  <= {24'h000000, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    hsize  <= 3'h0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    hsel   <= 1'b1;
    hsize  <= 3'h2;
    htrans <= 2'b10;
    hwrite <= 1'b0;
    haddr  <= {24'h000000, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    hsize  <= 3'h0;
    htrans <= 2'b00;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    d = hrdata[7:0];
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a, rv);
    `CHK(rv, e)
  endtask

  task automatic rdb(input logic [7:0] a, input int b, input logic e);
    rd(a, rv);
    `CHK(rv[b], e)
  endtask

  task automatic pulse();
    u_tgc_far.pin(1'b1);
    idle(20);
    u_tgc_far.pin(1'b0);
    idle(8);
  endtask

  task automatic t_overflow();
    u_tgc_far.pin(1'b1);
    rdc(TGC_OFF_PER_LIM, 8'hFF);
    rdc(8'h28, 8'h00);
    // Reset leaves an active-low gate open, so the raised pin closes it.
    rdc(TGC_OFF_IRQ, 8'h02);
    wr(TGC_OFF_CNT_HI, 8'hFF);
    wr(TGC_OFF_CNT_LO, 8'hF8);
    wr(TGC_OFF_IRQ, 8'h12);
    wr(TGC_OFF_CTRL, 8'h01);
    idle(40);
    wr(TGC_OFF_CTRL, 8'h00);
    rdc(TGC_OFF_CNT_HI, 8'h00);
    rdc(TGC_OFF_IRQ, 8'h11);
    `CHK(overflow_irq, 1'b1)
    wr(TGC_OFF_IRQ, 8'h00);
    idle(2);
    `CHK(overflow_irq, 1'b0)
    rdc(TGC_OFF_IRQ, 8'h01);
    wr(TGC_OFF_IRQ, 8'h01);
  endtask

  task automatic t_trigger();
    logic [1:0] asg;
    logic [3:0] mode;
    logic       hit;
    wr(TGC_OFF_CTRL, 8'h01);
    for (int i = 0; i < 7; i++) begin
      asg  = (i < 2 || i == 6) ? 2'b10 : (i < 4 ? 2'b01 : 2'b00);
      mode = (i == 6) ? 4'hA : TGC_CMP_SEVT;
      hit  = mode == TGC_CMP_SEVT && (asg == TGC_ASG_BOTH ||
             (asg == TGC_ASG_SECOND && i[0]));
      wr(TGC_OFF_ASSIGN, {6'h00, asg});
      wr(TGC_OFF_CNT_LO, 8'h00);
      wr(TGC_OFF_CNT_HI, 8'h12);
      u_tgc_far.fire(i[0], mode);
      idle(2);
      rdc(TGC_OFF_CNT_HI, hit ? 8'h00 : 8'h12);
    end
    wr(TGC_OFF_ASSIGN, 8'h02);
    // The trigger lands in the data phase of the count write.
    fork
      wr(TGC_OFF_CNT_HI, 8'h34);
      u_tgc_far.fire(1'b0, TGC_CMP_SEVT);
    join
    rdc(TGC_OFF_CNT_HI, 8'h34);
    // The trigger meets FFFFh; a pass lasts five cycles, so the two
    // passes see both phases of the tick.
    for (int j = 0; j < 2; j++) begin
      wr(TGC_OFF_CNT_HI, 8'hFF);
      fork
        wr(TGC_OFF_CNT_LO, 8'hFF);
        begin
          idle(1);
          u_tgc_far.fire(1'b0, TGC_CMP_SEVT);
        end
      join
    end
    rdc(TGC_OFF_IRQ, 8'h00);
  endtask

  task automatic t_gate();
    logic [7:0] a;
    for (int i = 0; i < 4; i++) begin
      wr(TGC_OFF_GATE, {1'b0, i[1], 6'h00});
      u_tgc_far.pin(i[0]);
      idle(8);
      rdb(TGC_OFF_GATE, TGC_GATE_VAL, i[0] == i[1]);
    end
    wr(TGC_OFF_GATE, 8'hC0);
    u_tgc_far.pin(1'b0);
    idle(8);
    rd(TGC_OFF_CNT_LO, a);
    idle(20);
    rdc(TGC_OFF_CNT_LO, a);
    u_tgc_far.pin(1'b1);
    idle(12);
    rd(TGC_OFF_CNT_LO, rv);
    `CHK(rv != a, 1'b1)
    wr(TGC_OFF_GATE, 8'h40);
    wr(TGC_OFF_IRQ, 8'h22);
    u_tgc_far.pin(1'b0);
    idle(8);
    rdc(TGC_OFF_IRQ, 8'h22);
    `CHK(gate_event_irq, 1'b1)
    wr(TGC_OFF_IRQ, 8'h02);
    rdc(TGC_OFF_IRQ, 8'h00);
  endtask

  task automatic t_toggle();
    wr(TGC_OFF_GATE, 8'h60);
    u_tgc_far.pin(1'b1);
    idle(8);
    rdb(TGC_OFF_GATE, TGC_GATE_VAL, 1'b1);
    u_tgc_far.pin(1'b0);
    idle(8);
    rdb(TGC_OFF_GATE, TGC_GATE_VAL, 1'b1);
    wr(TGC_OFF_GATE, 8'h40);
    idle(8);
    rdb(TGC_OFF_GATE, TGC_GATE_VAL, 1'b0);
    wr(TGC_OFF_GATE, 8'h60);
    idle(8);
    rdb(TGC_OFF_GATE, TGC_GATE_VAL, 1'b0);
  endtask

  task automatic t_single();
    logic [7:0] a;
    wr(TGC_OFF_GATE, 8'hD0);
    wr(TGC_OFF_GATE, 8'hD8);
    rdb(TGC_OFF_GATE, TGC_GATE_ARM, 1'b1);
    rd(TGC_OFF_CNT_LO, a);
    for (int i = 0; i < 2; i++) begin
      pulse();
      rdb(TGC_OFF_GATE, TGC_GATE_ARM, 1'b0);
      rd(TGC_OFF_CNT_LO, rv);
      `CHK(rv != a, i == 0)
      a = rv;
    end
    wr(TGC_OFF_GATE, 8'hD8);
    wr(TGC_OFF_GATE, 8'hC8);
    rdb(TGC_OFF_GATE, TGC_GATE_ARM, 1'b0);
    wr(TGC_OFF_GATE, 8'hF0);
    wr(TGC_OFF_GATE, 8'hF8);
    for (int i = 0; i < 2; i++) begin
      pulse();
      rdb(TGC_OFF_GATE, TGC_GATE_ARM, i == 0);
    end
  endtask

  task automatic t_source();
    wr(TGC_OFF_GATE, 8'h41);
    wr(TGC_OFF_IRQ, 8'h02);
    pulse();
    rdc(TGC_OFF_IRQ, 8'h00);
    wr(TGC_OFF_C8_CNT, 8'hFC);
    wr(TGC_OFF_AUX, 8'h01);
    idle(20);
    rdc(TGC_OFF_IRQ, 8'h02);
    wr(TGC_OFF_AUX, 8'h00);
    wr(TGC_OFF_GATE, 8'h42);
    wr(TGC_OFF_IRQ, 8'h02);
    wr(TGC_OFF_PER_LIM, 8'h03);
    wr(TGC_OFF_AUX, 8'h02);
    idle(20);
    rdc(TGC_OFF_IRQ, 8'h02);
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    failures = 0;
    check_count = 0;
    idle(12);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_overflow();
    t_trigger();
    t_gate();
    t_toggle();
    t_single();
    t_source();
    end_of_test();
  end

  // The scenarios need about six hundred and fifty cycles; this is ample.
  initial begin
    idle(12000);
    failures++;
    end_of_test();
  end
endmodule

bind tgc_timer3_gate tgc_monitor #(.TICK_DIV(TICK_DIV)) u_tgc_monitor (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .cmp1_mode_field(cmp1_mode_field), .cmp1_trigger(cmp1_trigger),
  .gate_event_irq(gate_event_irq), .overflow_irq(overflow_irq)
);

// >>> sim/tgc_far.sv
// Purpose: Far-side model of the gate pin and the compare units.
// Assumes: Called from bench tasks; changes land just after an edge.
// Notes:   Triggers are one-cycle pulses, never held.
`timescale 1ns/1ps
module tgc_far (
  input  wire logic       hclk,
  output logic            gate_input_pin,
  output logic      [3:0] cmp1_mode_field,
  output logic      [3:0] cmp2_mode_field,
  output logic            cmp1_trigger,
  output logic            cmp2_trigger
);
  initial begin
    gate_input_pin  = 1'b0;
    cmp1_mode_field = 4'h0;
    cmp2_mode_field = 4'h0;
    cmp1_trigger    = 1'b0;
    cmp2_trigger    = 1'b0;
  end

  task automatic pin(input logic v);
    @(posedge hclk);
    gate_input_pin <= v;
  endtask

  // The pulse is synchronous to hclk, as a timer-mode compare would be;
  // an asynchronous pulse could slip past the counter.
  task automatic fire(input logic second, input logic [3:0] mode);
    @(posedge hclk);
    cmp1_mode_field <= mode;
    cmp2_mode_field <= mode;
    cmp1_trigger    <= !second;
    cmp2_trigger    <= second;
    @(posedge hclk);
    cmp1_trigger <= 1'b0;
    cmp2_trigger <= 1'b0;
  endtask
endmodule

// >>> sim/tgc_monitor.sv
// Purpose: Concurrent checks on the ports of the timer gate block.
// Assumes: One clock; word transfers with hready taken from the slave.
// Notes:   Shadows the two request enables from bus writes.
`timescale 1ns/1ps
module tgc_monitor
  import tgc_pkg::*;
#(
  parameter int TICK_DIV = TGC_TICK_DIV
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic [3:0]  cmp1_mode_field,
  input wire logic        cmp1_trigger,
  input wire logic        gate_event_irq,
  input wire logic        overflow_irq
);
  logic       taken;
  logic       irq_wr_q;
  logic [1:0] irq_en_q;

  default clocking mon_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  assign taken = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_wr_q <= 1'b0;
    end else if (hready) begin
      irq_wr_q <= taken && hwrite && haddr[7:0] == TGC_OFF_IRQ;
    end
  end

  // The shadow lets the request lines be judged without a read back.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_q <= 2'b00;
    end else if (irq_wr_q && hready) begin
      irq_en_q <= {hwdata[TGC_IRQ_GEV_E], hwdata[TGC_IRQ_OVF_E]};
    end
  end

  okay_resp_a: assert property (hresp == 1'b0)
    else $error("slave response is not OKAY");
  read_wait_a: assert property (
    taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");
  write_nowait_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write was stalled");
  rdata_hold_a: assert property (
    hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data changed outside a read");
  rdata_upper_a: assert property (
    $rose(hreadyout) |-> hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  ovf_irq_gate_a: assert property (
    overflow_irq |-> $past(irq_en_q[0]))
    else $error("overflow request while its enable is clear");
  gev_irq_gate_a: assert property (
    gate_event_irq |-> $past(irq_en_q[1]))
    else $error("gate event request while its enable is clear");
  ovf_irq_off_a: assert property (
    irq_wr_q && hready && !hwdata[TGC_IRQ_OVF_E] |=> ##1 !overflow_irq)
    else $error("overflow request not dropped after disable");

  cover property ($rose(overflow_irq));
  cover property ($rose(gate_event_irq));
  cover property (cmp1_trigger && cmp1_mode_field == TGC_CMP_SEVT);
endmodule
